// *** inc/ash_pkg.sv ***
package ash_pkg;
   // Register byte offsets
   localparam logic [7:0] ADR_CMD  = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_ERR  = 8'h08;
   localparam logic [7:0] ADR_SERR = 8'h0C;
   localparam logic [7:0] ADR_FEED = 8'h10;
   localparam logic [7:0] ADR_MOVE = 8'h14;
   localparam logic [7:0] ADR_TIME = 8'h18;
   // Command register bit positions
   localparam int C_RSTOP = 0;
   localparam int C_JFWD  = 1;
   localparam int C_JREV  = 2;
   localparam int C_CCLR  = 3;
   localparam int C_SPEN  = 4;
   localparam int C_GAIN2 = 5;
   localparam int C_GAIN1 = 6;
   localparam int C_ERST  = 7;
   localparam int C_SERST = 8;
   localparam int C_BYP   = 9;
   localparam int C_RETN  = 10;
   localparam int C_SOFF  = 11;
   localparam int C_GSON  = 12;
   localparam int C_START = 13;
   localparam int C_MODE  = 14;
   localparam int C_DIR   = 16;
   // Start modes
   localparam logic [1:0] MODE_POS    = 2'h0;
   localparam logic [1:0] MODE_SPDPOS = 2'h1;
   localparam logic [1:0] MODE_INCSPD = 2'h2;
   localparam logic [1:0] MODE_SPDTRQ = 2'h3;
   // Gain selections
   localparam logic [1:0] GAIN_BASE = 2'h0;
   localparam logic [1:0] GAIN_ONE  = 2'h1;
   localparam logic [1:0] GAIN_TWO  = 2'h2;
   // Minor error codes, values arbitrary
   localparam logic [15:0] ERR_EXT_STOP = 16'h00A1;
   localparam logic [15:0] ERR_STROKE   = 16'h00A2;
   // Reset values, common constants and AXI response codes
   localparam logic [31:0] CMD_RST  = 32'h0000_0000;
   localparam logic [31:0] MOVE_RST = 32'h0000_0010;
   localparam logic [31:0] TIME_RST = 32'h0004_0008;
   localparam logic [15:0] ZERO16   = 16'h0000;
   localparam logic [31:0] ZERO32   = 32'h0000_0000;
   localparam logic [31:0] ONE32    = 32'h0000_0001;
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_POS   = 7'h02,
      ST_SPD   = 7'h04,
      ST_DWELL = 7'h08,
      ST_JOG   = 7'h10,
      ST_DECEL = 7'h20,
      ST_ZSPD  = 7'h40
   } ash_state_e;
endpackage

// *** logic/ash_axis_cmd.sv ***
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module ash_axis_cmd
   import ash_pkg::*;
#(
   parameter logic [31:0] STROKE_LIMIT = 32'h0001_0000
)(
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   input  wire logic        change_in,
   input  wire logic        ext_stop_in,
   input  wire logic        zero_speed_in,
   input  wire logic        minor_err_in,
   input  wire logic        major_err_in,
   input  wire logic [15:0] err_code_in,
   input  wire logic        servo_alarm_in,
   input  wire logic        servo_warn_in,
   input  wire logic [15:0] servo_code_in,
   output logic             amp_speed_zero_out,
   output logic             amp_pos_ctl_out,
   output logic             amp_gain_req_out,
   output logic [1:0]       amp_gain_sel_out,
   output logic             amp_servo_on_out,
   output logic             drive_fwd_out,
   output logic             drive_rev_out
);
   typedef struct packed {
      logic        aw;
      logic [7:0]  awaddr;
      logic        w;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] cmd;
      logic [31:0] move;
      logic [31:0] tmr;
      logic        chg1;
      logic        chg2;
      logic        es1;
      logic        es2;
      logic        es_prev;
      logic        zs1;
      logic        zs2;
      logic        start_prev;
      ash_state_e  st;
      logic [1:0]  mode;
      logic        dir;
      logic        edge_stop;
      logic        feed_upd;
      logic        retain;
      logic [15:0] cnt;
      logic [31:0] remain;
      logic [31:0] feed;
      logic        start_done;
      logic        pos_done;
      logic        accepted;
      logic        err_flag;
      logic [15:0] minor;
      logic [15:0] major;
      logic        serr_flag;
      logic [15:0] serr;
      logic        servo_off;
      logic        servo_on;
      logic        pos_ctl;
      logic        spd_zero;
      logic [1:0]  gain_sel;
      logic        drv_f;
      logic        drv_r;
   } ash_st_s;

   ash_st_s s_q;
   ash_st_s s_d;
   logic    start_rise;
   logic    stop_req;
   logic    rstop;

   function automatic logic [31:0] ash_merge(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
            r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction

   assign s_axi_awready_out  = !s_q.aw && !s_q.bvalid;
   assign s_axi_wready_out   = !s_q.w && !s_q.bvalid;
   assign s_axi_arready_out  = !s_q.rvalid;
   assign s_axi_bvalid_out   = s_q.bvalid;
   assign s_axi_bresp_out    = s_q.bresp;
   assign s_axi_rvalid_out   = s_q.rvalid;
   assign s_axi_rdata_out    = s_q.rdata;
   assign s_axi_rresp_out    = s_q.rresp;
   assign amp_speed_zero_out = s_q.spd_zero;
   assign amp_pos_ctl_out    = s_q.pos_ctl;
   assign amp_gain_req_out   = s_q.gain_sel[1];
   assign amp_gain_sel_out   = s_q.gain_sel;
   assign amp_servo_on_out   = s_q.servo_on;
   assign drive_fwd_out      = s_q.drv_f;
   assign drive_rev_out      = s_q.drv_r;

   assign start_rise = s_q.cmd[C_START] && !s_q.start_prev;
   assign rstop      = s_q.cmd[C_RSTOP];
   // Stop pin is a level normally, an edge after a bypassed start
   assign stop_req   = s_q.edge_stop ? (s_q.es2 && !s_q.es_prev)
                                     : s_q.es2;

   always_comb
   begin
      s_d = s_q;
      // Change, stop and zero-speed pins pass two flops before any use
      s_d.chg1       = change_in;
      s_d.chg2       = s_q.chg1;
      s_d.es1        = ext_stop_in;
      s_d.es2        = s_q.es1;
      s_d.es_prev    = s_q.es2;
      s_d.zs1        = zero_speed_in;
      s_d.zs2        = s_q.zs1;
      s_d.start_prev = s_q.cmd[C_START];
      // Write channel: both halves in either order, one at a time
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
         s_d.aw     = 1'b1;
         s_d.awaddr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
         s_d.w     = 1'b1;
         s_d.wdata = s_axi_wdata_in;
         s_d.wstrb = s_axi_wstrb_in;
      end
      if (s_q.bvalid && s_axi_bready_in)
         s_d.bvalid = 1'b0;
      if (s_q.aw && s_q.w && !s_q.bvalid)
      begin
         s_d.aw     = 1'b0;
         s_d.w      = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OK;
         case ({s_q.awaddr[7:2], 2'h0})
            ADR_CMD:  s_d.cmd  = ash_merge(s_q.cmd, s_q.wdata, s_q.wstrb);
            ADR_MOVE: s_d.move = ash_merge(s_q.move, s_q.wdata, s_q.wstrb);
            ADR_TIME: s_d.tmr  = ash_merge(s_q.tmr, s_q.wdata, s_q.wstrb);
            ADR_STAT, ADR_ERR, ADR_SERR, ADR_FEED: s_d.bresp = RESP_OK;
            default:  s_d.bresp = RESP_ERR;
         endcase
      end
      // Read channel
      if (s_q.rvalid && s_axi_rready_in)
         s_d.rvalid = 1'b0;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OK;
         case ({s_axi_araddr_in[7:2], 2'h0})
            ADR_CMD:  s_d.rdata = s_q.cmd;
            ADR_STAT: s_d.rdata = {9'h000, s_q.st, 6'h00, s_q.gain_sel,
                                   s_q.spd_zero, s_q.pos_ctl, s_q.servo_on,
                                   s_q.serr_flag, s_q.err_flag, s_q.accepted,
                                   s_q.pos_done, s_q.start_done};
            ADR_ERR:  s_d.rdata = {s_q.major, s_q.minor};
            ADR_SERR: s_d.rdata = {ZERO16, s_q.serr};
            ADR_FEED: s_d.rdata = s_q.feed;
            ADR_MOVE: s_d.rdata = s_q.move;
            ADR_TIME: s_d.rdata = s_q.tmr;
            default:
            begin
               s_d.rdata = ZERO32;
               s_d.rresp = RESP_ERR;
            end
         endcase
      end
      // Error stores: a new error in the reset cycle survives
      if (s_q.cmd[C_ERST] && s_q.err_flag)
      begin
         s_d.minor    = ZERO16;
         s_d.major    = ZERO16;
         s_d.err_flag = 1'b0;
      end
      if (minor_err_in)
      begin
         s_d.minor    = err_code_in;
         s_d.err_flag = 1'b1;
      end
      if (major_err_in)
      begin
         s_d.major    = err_code_in;
         s_d.err_flag = 1'b1;
      end
      if (s_q.cmd[C_SERST])
      begin
         s_d.serr      = ZERO16;
         s_d.serr_flag = 1'b0;
      end
      if (servo_warn_in)
         s_d.serr = servo_code_in;
      if (servo_alarm_in)
      begin
         s_d.serr      = servo_code_in;
         s_d.serr_flag = 1'b1;
      end
      // Clear first so that a completion in the same cycle wins
      if (s_q.cmd[C_CCLR])
      begin
         s_d.start_done = 1'b0;
         s_d.pos_done   = 1'b0;
      end
      s_d.gain_sel = s_q.cmd[C_GAIN2] ? GAIN_TWO :
                     (s_q.cmd[C_GAIN1] ? GAIN_ONE : GAIN_BASE);
      case (s_q.st)
         ST_IDLE:
         begin
            if (start_rise)
            begin
               if (s_q.es2 && !s_q.cmd[C_BYP])
               begin
                  s_d.minor    = ERR_EXT_STOP;
                  s_d.err_flag = 1'b1;
               end
               else
               begin
                  s_d.edge_stop  = s_q.cmd[C_BYP];
                  s_d.accepted   = 1'b1;
                  s_d.start_done = 1'b1;
                  s_d.pos_done   = 1'b0;
                  s_d.mode       = s_q.cmd[C_MODE +: 2];
                  s_d.dir        = s_q.cmd[C_DIR];
                  s_d.remain     = s_q.move;
                  // Retain is taken once here; a later drop is not seen
                  s_d.retain     = s_q.cmd[C_RETN];
                  s_d.feed       = s_q.cmd[C_RETN] ? s_q.feed
                                                   : ZERO32;
                  s_d.feed_upd   = s_q.cmd[C_RETN] ||
                                   (s_q.cmd[C_MODE +: 2] != MODE_INCSPD);
                  s_d.pos_ctl    = (s_q.cmd[C_MODE +: 2] == MODE_POS);
                  s_d.st = (s_q.cmd[C_MODE +: 2] == MODE_POS) ? ST_POS
                                                              : ST_SPD;
               end
            end
            else if (s_q.cmd[C_JFWD] || s_q.cmd[C_JREV])
            begin
               s_d.st        = ST_JOG;
               s_d.accepted  = 1'b1;
               s_d.edge_stop = 1'b0;
               s_d.dir       = s_q.cmd[C_JFWD];
            end
         end
         ST_POS:
         begin
            s_d.feed   = s_q.dir ? s_q.feed + ONE32 : s_q.feed - ONE32;
            s_d.remain = s_q.remain - ONE32;
            if (rstop)
            begin
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
            end
            else if (stop_req)
            begin
               s_d.st  = ST_DECEL;
               s_d.cnt = s_q.tmr[15:0];
            end
            else if (s_q.remain <= ONE32)
            begin
               s_d.st  = ST_DWELL;
               s_d.cnt = s_q.tmr[31:16];
            end
         end
         ST_SPD:
         begin
            if (s_q.feed_upd)
               s_d.feed = s_q.dir ? s_q.feed + ONE32 : s_q.feed - ONE32;
            if (rstop)
            begin
               if (s_q.mode == MODE_SPDTRQ)
                  s_d.st = ST_ZSPD;
               else
               begin
                  s_d.st       = ST_IDLE;
                  s_d.accepted = 1'b0;
               end
            end
            else if (stop_req)
            begin
               s_d.st  = ST_DECEL;
               s_d.cnt = s_q.tmr[15:0];
            end
            else if (s_q.mode == MODE_SPDPOS && s_q.cmd[C_SPEN] &&
                     s_q.chg2)
            begin
               s_d.st      = ST_POS;
               s_d.pos_ctl = 1'b1;
            end
            else if (s_q.mode == MODE_INCSPD && s_q.retain &&
                     (s_q.feed == STROKE_LIMIT ||
                      s_q.feed == (~STROKE_LIMIT + ONE32)))
            begin
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
               s_d.minor    = ERR_STROKE;
               s_d.err_flag = 1'b1;
               // Stop at the limit, never one step past it
               s_d.feed     = s_q.feed;
            end
         end
         ST_ZSPD:
         begin
            if (s_q.zs2)
            begin
               s_d.pos_ctl  = 1'b1;
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
            end
         end
         ST_DWELL:
         begin
            // Rapid stop has no effect here
            if (s_q.cnt == ZERO16)
            begin
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
               s_d.pos_done = 1'b1;
            end
            else
               s_d.cnt = s_q.cnt - 16'h0001;
         end
         ST_JOG:
         begin
            s_d.feed = s_q.dir ? s_q.feed + ONE32 : s_q.feed - ONE32;
            if (rstop)
            begin
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
            end
            else if (s_q.dir ? !s_q.cmd[C_JFWD]
                             : !s_q.cmd[C_JREV])
            begin
               s_d.st  = ST_DECEL;
               s_d.cnt = s_q.tmr[15:0];
            end
         end
         ST_DECEL:
         begin
            if (rstop || s_q.cnt == ZERO16)
            begin
               s_d.st       = ST_IDLE;
               s_d.accepted = 1'b0;
            end
            else
            begin
               s_d.cnt  = s_q.cnt - 16'h0001;
               s_d.feed = s_q.dir ? s_q.feed + ONE32 : s_q.feed - ONE32;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
      if (s_q.st == ST_IDLE)
         s_d.servo_off = s_q.cmd[C_SOFF];
      s_d.servo_on = s_q.cmd[C_GSON] && !s_d.servo_off;
      s_d.spd_zero = (s_d.st == ST_ZSPD);
      s_d.drv_f    = s_d.dir && (s_d.st == ST_POS || s_d.st == ST_SPD ||
                     s_d.st == ST_JOG || s_d.st == ST_DECEL);
      s_d.drv_r    = !s_d.dir && (s_d.st == ST_POS || s_d.st == ST_SPD ||
                     s_d.st == ST_JOG || s_d.st == ST_DECEL);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.cmd  <= CMD_RST;
         s_q.move <= MOVE_RST;
         s_q.tmr  <= TIME_RST;
      end
      else
         s_q <= s_d;
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   property p_zspd;
      s_q.st == ST_SPD && s_q.mode == MODE_SPDTRQ && rstop
      |=> s_q.st == ST_ZSPD && amp_speed_zero_out ##0 !drive_fwd_out;
   endproperty
   a_zspd: assert property (p_zspd)
      else $error("rapid stop did not command zero speed");

   property p_dwell_end;
      s_q.st == ST_DWELL && s_q.cnt == ZERO16
      |=> s_q.pos_done && !s_q.accepted && s_q.st == ST_IDLE;
   endproperty
   a_dwell_end: assert property (p_dwell_end)
      else $error("dwell end did not complete positioning");

   property p_dwell_hold;
      s_q.st == ST_DWELL && s_q.cnt != ZERO16 |=> s_q.st == ST_DWELL;
   endproperty
   a_dwell_hold: assert property (p_dwell_hold)
      else $error("dwell left early");

   property p_jog_fwd;
      s_q.st == ST_JOG && s_q.dir && s_q.cmd[C_JFWD] && !rstop
      |=> s_q.feed == $past(s_q.feed) + ONE32 && drive_fwd_out;
   endproperty
   a_jog_fwd: assert property (p_jog_fwd)
      else $error("forward jog not moving up");

   property p_jog_rev_rel;
      s_q.st == ST_JOG && !s_q.dir && !s_q.cmd[C_JREV] && !rstop
      |=> s_q.st == ST_DECEL && s_q.cnt == $past(s_q.tmr[15:0]);
   endproperty
   a_jog_rev_rel: assert property (p_jog_rev_rel)
      else $error("reverse jog release did not decelerate");

   property p_cclr;
      s_q.cmd[C_CCLR] && !start_rise && s_q.st != ST_DWELL
      |=> !s_q.start_done && !s_q.pos_done;
   endproperty
   a_cclr: assert property (p_cclr)
      else $error("completion clear ignored");

   property p_change;
      s_q.st == ST_SPD && s_q.mode == MODE_SPDPOS && s_q.cmd[C_SPEN] &&
      s_q.chg2 && !rstop && !stop_req |=> s_q.st == ST_POS && amp_pos_ctl_out;
   endproperty
   a_change: assert property (p_change)
      else $error("CHANGE did not switch to position");

   property p_nochange;
      s_q.st == ST_SPD && !s_q.cmd[C_SPEN] |=> s_q.st != ST_POS;
   endproperty
   a_nochange: assert property (p_nochange)
      else $error("switch happened while disabled");

   property p_gain;
      s_q.cmd[C_GAIN2] |=> amp_gain_req_out && amp_gain_sel_out == GAIN_TWO;
   endproperty
   a_gain: assert property (p_gain)
      else $error("second gain not applied");

   property p_erst;
      s_q.cmd[C_ERST] && s_q.err_flag && !minor_err_in && !major_err_in
      && s_q.st != ST_SPD |=> !s_q.err_flag && s_q.minor == ZERO16
      && s_q.major == ZERO16;
   endproperty
   a_erst: assert property (p_erst)
      else $error("error reset did not clear");

   property p_serst;
      s_q.cmd[C_SERST] && !servo_alarm_in && !servo_warn_in
      |=> s_q.serr == ZERO16 && !s_q.serr_flag;
   endproperty
   a_serst: assert property (p_serst)
      else $error("servo error reset did not clear");

   property p_refuse;
      s_q.st == ST_IDLE && start_rise && s_q.es2 && !s_q.cmd[C_BYP]
      |=> s_q.st == ST_IDLE && s_q.err_flag && !s_q.accepted;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("start taken with stop input high");

   property p_servo_hold;
      s_q.st != ST_IDLE |=> s_q.servo_off == $past(s_q.servo_off);
   endproperty
   a_servo_hold: assert property (p_servo_hold)
      else $error("servo off changed while positioning");
endmodule

// *** dv/ash_amp_model.sv ***
module ash_amp_model
(
   input  wire logic mclk_in,
   input  wire logic rst_n_in,
   input  wire logic zero_req_in,
   output logic      zero_speed_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_q;
   // Motor needs a few cycles to coast to zero; never answers at once
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt_q <= 2'h0;
      else if (!zero_req_in)
         cnt_q <= 2'h0;
      else if (cnt_q != 2'h3)
         cnt_q <= cnt_q + 2'h1;
   end
   assign zero_speed_out = (cnt_q == 2'h3);
endmodule

// *** dv/ash_axis_cmd_tb.sv ***
module ash_axis_cmd_tb
   import ash_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in = 0, rst_n_in = 0, change_in = 0, ext_stop_in = 0;
   logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic        s_axi_arvalid_in = 0, s_axi_rready_in = 0, zero_speed_in;
   logic        minor_err_in = 0, major_err_in = 0;
   logic        servo_alarm_in = 0, servo_warn_in = 0;
   logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
   logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, rd_q;
   logic [3:0]  s_axi_wstrb_in = 4'hF;
   logic [15:0] err_code_in = 0, servo_code_in = 0;
   logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic        s_axi_arready_out, s_axi_rvalid_out, amp_speed_zero_out;
   logic        amp_pos_ctl_out, amp_gain_req_out, amp_servo_on_out;
   logic        drive_fwd_out, drive_rev_out;
   logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, amp_gain_sel_out, rr, br;
   int          n_fail = 0, checks = 0;

   ash_axis_cmd #(.STROKE_LIMIT(32'h10)) u_ash_axis_cmd (.*);
   ash_amp_model u_ash_amp_model (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .zero_req_in(amp_speed_zero_out), .zero_speed_out(zero_speed_in));

   initial
      forever #20 mclk_in = ~mclk_in;

   task finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task tmo;
      n_fail++;
      $display("Error %0t: timeout", $time);
      finish_test;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'h1;
      s_axi_wvalid_in <= 1'h1;
      s_axi_bready_in <= 1'h1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge mclk_in);
         if (s_axi_bvalid_out)
            break;
         if (s_axi_awready_out)
            s_axi_awvalid_in <= 1'h0;
         if (s_axi_wready_out)
            s_axi_wvalid_in <= 1'h0;
      end
      br = s_axi_bresp_out;
      s_axi_bready_in <= 1'h0;
      if (i == 50)
         tmo;
   endtask
   task rd(input logic [7:0] a);
      int i;
      @(posedge mclk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'h1;
      s_axi_rready_in <= 1'h1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge mclk_in);
         if (s_axi_rvalid_out)
            break;
         if (s_axi_arready_out)
            s_axi_arvalid_in <= 1'h0;
      end
      rd_q = s_axi_rdata_out;
      rr = s_axi_rresp_out;
      s_axi_rready_in <= 1'h0;
      if (i == 50)
         tmo;
   endtask
   // Polls because axis state moves on its own; bounded so a hang fails
   task rdp(input logic [7:0] a, input logic [31:0] m, e);
      int i;
      for (i = 0; i < 40; i++)
      begin
         rd(a);
         if ((rd_q & m) === e)
            break;
      end
      chk(rd_q & m, e);
   endtask
   task srv(input logic al, wn, input logic [15:0] c);
      @(posedge mclk_in);
      servo_alarm_in <= al;
      servo_warn_in <= wn;
      servo_code_in <= c;
      @(posedge mclk_in);
      servo_alarm_in <= 1'h0;
      servo_warn_in <= 1'h0;
   endtask

   initial
   begin
      repeat (12) @(posedge mclk_in);
      rst_n_in <= 1'h1;
      rdp(ADR_TIME, 32'hFFFFFFFF, TIME_RST);
      rd(8'h1C);
      chk(32'(rr), 32'(RESP_ERR));
      wr(8'h1C, ZERO32);
      chk(32'(br), 32'(RESP_ERR));
      wr(ADR_CMD, 32'h60);
      chk(32'(br), 32'(RESP_OK));
      rdp(ADR_STAT, 32'h300, 32'h200);
      chk(32'(amp_gain_sel_out), 32'(GAIN_TWO));
      chk(32'(amp_gain_req_out), ONE32);
      ext_stop_in <= 1'h1;
      wr(ADR_CMD, ZERO32);
      wr(ADR_CMD, 32'h2000);
      rdp(ADR_ERR, 32'hFFFF, {16'h0, ERR_EXT_STOP});
      chk(32'(amp_gain_req_out), ZERO32);
      wr(ADR_CMD, 32'h80);
      rdp(ADR_STAT, 32'h8, ZERO32);
      rdp(ADR_ERR, 32'hFFFFFFFF, ZERO32);
      wr(ADR_CMD, 32'h200);
      wr(ADR_CMD, 32'h2200);
      rdp(ADR_STAT, 32'h4, 32'h4);
      rdp(ADR_STAT, 32'h7, 32'h3);
      wr(ADR_CMD, 32'h8);
      rdp(ADR_STAT, 32'h3, ZERO32);
      wr(ADR_CMD, ZERO32);
      ext_stop_in <= 1'h0;
      wr(ADR_CMD, 32'h2);
      rdp(ADR_STAT, 32'h7F0000, 32'h100000);
      chk(32'(drive_fwd_out), ONE32);
      wr(ADR_CMD, ZERO32);
      rdp(ADR_STAT, 32'h7F0000, 32'h10000);
      wr(ADR_CMD, 32'h4);
      rdp(ADR_STAT, 32'h7F0000, 32'h100000);
      chk(32'(drive_rev_out), ONE32);
      wr(ADR_CMD, ZERO32);
      rdp(ADR_STAT, 32'h7F0000, 32'h10000);
      srv(1'h1, 1'h0, 16'h1234);
      rdp(ADR_STAT, 32'h10, 32'h10);
      wr(ADR_CMD, 32'h100);
      rdp(ADR_SERR, 32'hFFFFFFFF, ZERO32);
      rdp(ADR_STAT, 32'h10, ZERO32);
      wr(ADR_CMD, ZERO32);
      srv(1'h0, 1'h1, 16'h0055);
      rdp(ADR_SERR, 32'hFFFFFFFF, 32'h55);
      wr(ADR_CMD, 32'h100);
      rdp(ADR_SERR, 32'hFFFFFFFF, ZERO32);
      wr(ADR_CMD, 32'hC000);
      wr(ADR_CMD, 32'hE000);
      wr(ADR_CMD, 32'hE001);
      rdp(ADR_STAT, 32'h80, 32'h80);
      chk(32'(amp_speed_zero_out), ONE32);
      rdp(ADR_STAT, 32'h40, 32'h40);
      chk(32'(amp_pos_ctl_out), ONE32);
      wr(ADR_CMD, 32'h1000);
      rdp(ADR_STAT, 32'h20, 32'h20);
      wr(ADR_CMD, 32'h1800);
      rdp(ADR_STAT, 32'h20, ZERO32);
      wr(ADR_CMD, 32'h1000);
      wr(ADR_CMD, 32'h3000);
      wr(ADR_CMD, 32'h1800);
      chk(32'(amp_servo_on_out), ONE32);
      rdp(ADR_STAT, 32'h27, 32'h3);
      change_in <= 1'h1;
      wr(ADR_CMD, 32'h6000);
      rdp(ADR_STAT, 32'h7F0040, 32'h40000);
      wr(ADR_CMD, 32'h4010);
      rdp(ADR_STAT, 32'h7F0040, 32'h20040);
      rdp(ADR_STAT, 32'h7, 32'h3);
      change_in <= 1'h0;
      wr(ADR_CMD, 32'hA000);
      rdp(ADR_FEED, 32'hFFFFFFFF, ZERO32);
      wr(ADR_CMD, 32'h8001);
      rdp(ADR_STAT, 32'h7F0000, 32'h10000);
      wr(ADR_CMD, 32'h1A400);
      rdp(ADR_ERR, 32'hFFFF, {16'h0, ERR_STROKE});
      rdp(ADR_FEED, 32'hFFFFFFFF, 32'h10);
      ext_stop_in <= 1'h1;
      wr(ADR_CMD, 32'h4200);
      wr(ADR_CMD, 32'h6200);
      rdp(ADR_STAT, 32'h7F0000, 32'h40000);
      ext_stop_in <= 1'h0;
      repeat (4) @(posedge mclk_in);
      ext_stop_in <= 1'h1;
      rdp(ADR_STAT, 32'h7F0000, 32'h10000);
      finish_test;
   end
   initial
   begin
      repeat (90000) @(posedge mclk_in);
      tmo;
   end
endmodule
